// ### design/fxr_ctrl_cfg.svh
// Offsets, fields, reset values and timing counts of the reference control block
`ifndef FXR_CTRL_CFG_SVH
`define FXR_CTRL_CFG_SVH
`define FXR_REG_CONTROL_ADDR 4'h0
`define FXR_BIT_ENABLE 7
`define FXR_BIT_READY 6
`define FXR_CONV_LSB 0
`define FXR_CMP_LSB 2
`define FXR_CONTROL_RESET 8'h00
`define FXR_CONTROL_WMASK 8'h8F
`define FXR_SETTLE_NS 25000
`define FXR_CLK_PERIOD_NS 10
`define FXR_SETTLE_CYCLES ((`FXR_SETTLE_NS + `FXR_CLK_PERIOD_NS - 1) / `FXR_CLK_PERIOD_NS)
`endif

// ### design/fxr_ctrl_pkg.sv
// Types shared by the reference control block
package fxr_ctrl_pkg;
    typedef enum logic [1:0] {
        FXR_GAIN_OFF = 2'b00,
        FXR_GAIN_X1 = 2'b01,
        FXR_GAIN_X2 = 2'b10,
        FXR_GAIN_X4 = 2'b11
    } fxr_gain_t;
    typedef enum logic [1:0] {
        FXR_ST_OFF = 2'b00,
        FXR_ST_SETTLE = 2'b01,
        FXR_ST_READY = 2'b10
    } fxr_state_t;
endpackage : fxr_ctrl_pkg

// ### design/fxr_gain_stage.sv
// One programmable gain stage: decodes a gain code into one-hot level selects
`timescale 1ns/100ps
module fxr_gain_stage
    import fxr_ctrl_pkg::*;
#(
    parameter bit ALLOW_X4 = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic [1:0] i_code,
    output logic [2:0] o_level_sel
);
    typedef struct packed {
        logic [2:0] sel;
    } fxr_gst_t;
    fxr_gst_t st_r;
    fxr_gst_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sel = 3'h0;
        if (i_enable) begin
            case (fxr_gain_t'(i_code))
                FXR_GAIN_OFF: st_nxt.sel = 3'h0;
                FXR_GAIN_X1: st_nxt.sel = 3'h1;
                FXR_GAIN_X2: st_nxt.sel = 3'h2;
                FXR_GAIN_X4: st_nxt.sel = ALLOW_X4 ? 3'h4 : 3'h0;
                default: st_nxt.sel = 3'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_level_sel = st_r.sel;

    a_gain_x4_block: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !ALLOW_X4 |-> !o_level_sel[2]
    ) else $error("four times level offered where barred");
    a_gain_off_dis: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !i_enable |=> o_level_sel == 3'h0
    ) else $error("level active while disabled");
endmodule : fxr_gain_stage

// ### design/fxr_settle_timer.sv
// Settling timer: counts cycles after enable and raises settled
`timescale 1ns/100ps
module fxr_settle_timer
    import fxr_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = 2500
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    output logic o_settled
);
    typedef struct packed {
        fxr_state_t state;
        logic [15:0] count;
    } fxr_tst_t;
    localparam logic [15:0] LAST = 16'(SETTLE_CYCLES - 1);
    fxr_tst_t st_r;
    fxr_tst_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            FXR_ST_OFF: begin
                st_nxt.count = 16'h0000;
                if (i_enable) begin
                    st_nxt.state = FXR_ST_SETTLE;
                end
            end
            FXR_ST_SETTLE: begin
                if (!i_enable) begin
                    st_nxt.state = FXR_ST_OFF;
                end else if (st_r.count == LAST) begin
                    st_nxt.state = FXR_ST_READY;
                end else begin
                    st_nxt.count = st_r.count + 16'h0001;
                end
            end
            FXR_ST_READY: begin
                if (!i_enable) begin
                    st_nxt.state = FXR_ST_OFF;
                end
            end
            default: st_nxt.state = FXR_ST_OFF;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '{state: FXR_ST_OFF, count: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_settled = (st_r.state == FXR_ST_READY);

    a_settle_not_early: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(i_enable) && st_r.state == FXR_ST_OFF |=> !o_settled [*2]
    ) else $error("settled too early");
endmodule : fxr_settle_timer

// ### design/fxr_ctrl_top.sv
// Fixed reference control register with Avalon-MM slave, settle timer and gain stages
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "fxr_ctrl_cfg.svh"
module fxr_ctrl_top
    import fxr_ctrl_pkg::*;
#(
    parameter bit HAS_LDO = 1'b0,
    parameter bit LOW_VOLTAGE = 1'b0,
    parameter int SETTLE_CYCLES = `FXR_SETTLE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    output logic o_ref_enable,
    output logic o_ref_ready,
    output logic [2:0] o_conv_level_sel,
    output logic [2:0] o_cmp_level_sel
);
    typedef struct packed {
        logic [7:0] control;
        logic busy;
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic enable;
        logic ready;
    } fxr_top_st_t;

    fxr_top_st_t st_r;
    fxr_top_st_t st_nxt;
    logic settled;
    logic [2:0] conv_sel;
    logic [2:0] cmp_sel;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE = 2'h3;

    function automatic logic [7:0] fxr_read_value(input logic [7:0] ctl, input logic rdy);
        logic [7:0] v;
        v = ctl & `FXR_CONTROL_WMASK;
        v[`FXR_BIT_READY] = rdy;
        return v;
    endfunction : fxr_read_value

    function automatic logic fxr_addr_hit(input logic [3:0] adr);
        return adr == `FXR_REG_CONTROL_ADDR;
    endfunction : fxr_addr_hit

    function automatic logic [7:0] fxr_write_value(input logic [31:0] wd);
        return wd[7:0] & `FXR_CONTROL_WMASK;
    endfunction : fxr_write_value

    fxr_settle_timer #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_enable(st_r.enable),
        .o_settled(settled)
    );

    fxr_gain_stage #(
        .ALLOW_X4(!LOW_VOLTAGE)
    ) u_conv_gain (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_enable(st_r.enable),
        .i_code(st_r.control[`FXR_CONV_LSB +: 2]),
        .o_level_sel(conv_sel)
    );

    fxr_gain_stage #(
        .ALLOW_X4(1'b1)
    ) u_cmp_gain (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_enable(st_r.enable),
        .i_code(st_r.control[`FXR_CMP_LSB +: 2]),
        .o_level_sel(cmp_sel)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.busy = 1'b0;
        if ((i_avs_read || i_avs_write) && !st_r.busy) begin
            // Latch the answer now; it is shown with waitrequest low one cycle later
            st_nxt.busy = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            st_nxt.resp = RESP_OKAY;
            if (!fxr_addr_hit(i_avs_address)) begin
                st_nxt.resp = RESP_DECODE;
            end else if (i_avs_read) begin
                st_nxt.rdata = {24'h00_0000, fxr_read_value(st_r.control, st_r.ready)};
            end
        end
        // A write lands only at the edge where the master sees waitrequest low
        if (i_avs_write && st_r.busy && fxr_addr_hit(i_avs_address) && i_avs_byteenable[0]) begin
            st_nxt.control = fxr_write_value(i_avs_writedata);
        end
        st_nxt.waitreq = !st_nxt.busy;
        st_nxt.enable = st_r.control[`FXR_BIT_ENABLE];
        st_nxt.ready = HAS_LDO ? 1'b1 : (settled && st_r.enable);
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '{
                control: `FXR_CONTROL_RESET,
                busy: 1'b0,
                waitreq: 1'b1,
                rdata: 32'h0000_0000,
                resp: 2'h0,
                enable: 1'b0,
                ready: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_avs_waitrequest = st_r.waitreq;
    assign o_avs_readdata = st_r.rdata;
    assign o_avs_response = st_r.resp;
    assign o_ref_enable = st_r.enable;
    assign o_ref_ready = st_r.ready;
    assign o_conv_level_sel = conv_sel;
    assign o_cmp_level_sel = cmp_sel;

    // Reference enable, ready flag, reserved bits and control writes
    a_enable_follow: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        st_r.control[`FXR_BIT_ENABLE]
        |=> o_ref_enable
    ) else $error("enable not following bit");
    a_enable_drop: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !st_r.control[`FXR_BIT_ENABLE]
        |=> !o_ref_enable
    ) else $error("enable stays on after clear");
    a_paths_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !o_ref_enable
        |=> o_conv_level_sel == 3'h0 && o_cmp_level_sel == 3'h0
    ) else $error("level path active while disabled");
    a_ready_when_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !HAS_LDO && !o_ref_enable
        |=> !o_ref_ready
    ) else $error("ready while disabled");
    a_settle_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !HAS_LDO && o_ref_enable && !settled
        |=> !o_ref_ready
    ) else $error("ready before settling");
    a_ready_settled: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !HAS_LDO && o_ref_ready
        |-> $past(settled)
    ) else $error("ready without settled timer");
    a_ready_bit_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_read && !st_r.busy && fxr_addr_hit(i_avs_address)
        |=> o_avs_readdata[`FXR_BIT_READY] == $past(o_ref_ready)
    ) else $error("read ready bit differs from flag");
    a_ready_ldo_one: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        HAS_LDO
        |=> o_ref_ready
    ) else $error("ready not one with regulator");
    a_resv_read_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_avs_readdata[5:4] == 2'h0
    ) else $error("reserved bits read nonzero");
    a_resv_ctl_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        st_r.control[6:4] == 3'h0
    ) else $error("read-only or reserved bits stored");
    a_write_lands: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_write && st_r.busy && fxr_addr_hit(i_avs_address) && i_avs_byteenable[0]
        |=> st_r.control == fxr_write_value($past(i_avs_writedata))
    ) else $error("write did not land");

    // Gain stages
    a_stage_indep: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[3:0] == 4'h9
        |=> o_cmp_level_sel == 3'h2 && o_conv_level_sel == 3'h1
    ) else $error("stages not independent");
    a_level_onehot: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        $onehot0(o_conv_level_sel) && $onehot0(o_cmp_level_sel)
    ) else $error("more than one level selected");
    a_conv_off_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CONV_LSB +: 2] == FXR_GAIN_OFF
        |=> o_conv_level_sel == 3'h0
    ) else $error("conv off wrong");
    a_conv_x1_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CONV_LSB +: 2] == FXR_GAIN_X1
        |=> o_conv_level_sel == 3'h1
    ) else $error("conv x1 wrong");
    a_conv_x2_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CONV_LSB +: 2] == FXR_GAIN_X2
        |=> o_conv_level_sel == 3'h2
    ) else $error("conv x2 wrong");
    a_read_gains: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_read && !st_r.busy && fxr_addr_hit(i_avs_address)
        |=> o_avs_readdata[3:0] == $past(st_r.control[3:0])
    ) else $error("gain fields read wrong");
    a_cmp_off_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CMP_LSB +: 2] == FXR_GAIN_OFF
        |=> o_cmp_level_sel == 3'h0
    ) else $error("cmp off wrong");
    a_cmp_x1_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CMP_LSB +: 2] == FXR_GAIN_X1
        |=> o_cmp_level_sel == 3'h1
    ) else $error("cmp x1 wrong");
    a_cmp_x2_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CMP_LSB +: 2] == FXR_GAIN_X2
        |=> o_cmp_level_sel == 3'h2
    ) else $error("cmp x2 wrong");
    a_cmp_x4_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_ref_enable && st_r.control[`FXR_CMP_LSB +: 2] == FXR_GAIN_X4
        |=> o_cmp_level_sel == 3'h4
    ) else $error("cmp x4 wrong");
    a_conv_x4_map: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !LOW_VOLTAGE && o_ref_enable && st_r.control[`FXR_CONV_LSB +: 2] == FXR_GAIN_X4
        |=> o_conv_level_sel == 3'h4
    ) else $error("conv x4 wrong");
    a_conv_lv_bar: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        LOW_VOLTAGE
        |-> !o_conv_level_sel[2]
    ) else $error("conv x4 on low voltage");
    a_conv_lv_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        LOW_VOLTAGE && o_ref_enable && st_r.control[`FXR_CONV_LSB +: 2] == FXR_GAIN_X4
        |=> o_conv_level_sel == 3'h0
    ) else $error("conv x4 code not off on low voltage");

    // Bus handshake and responses
    a_wait_one: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_avs_read || i_avs_write) && !st_r.busy
        |-> o_avs_waitrequest
    ) else $error("no wait on first cycle");
    a_wait_release: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        st_r.busy
        |-> !o_avs_waitrequest
    ) else $error("answer cycle still waits");
    a_busy_one_cycle: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        st_r.busy
        |=> !st_r.busy
    ) else $error("answer held longer than one cycle");
    a_resp_mapped: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_avs_read || i_avs_write) && !st_r.busy && fxr_addr_hit(i_avs_address)
        |=> o_avs_response == RESP_OKAY
    ) else $error("mapped access not answered okay");
    a_resp_unmapped: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_avs_read || i_avs_write) && !st_r.busy && !fxr_addr_hit(i_avs_address)
        |=> o_avs_response == RESP_DECODE && o_avs_readdata == 32'h0000_0000
    ) else $error("unmapped access not refused");
    a_write_unmapped: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_write && !fxr_addr_hit(i_avs_address)
        |=> $stable(st_r.control)
    ) else $error("unmapped write changed control");
    a_write_no_lane: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_write && !i_avs_byteenable[0]
        |=> $stable(st_r.control)
    ) else $error("write without lane changed control");
    a_enable_bit_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_avs_read && !st_r.busy && fxr_addr_hit(i_avs_address)
        |=> o_avs_readdata[`FXR_BIT_ENABLE] == $past(st_r.control[`FXR_BIT_ENABLE])
    ) else $error("enable bit read wrong");
    a_read_upper_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_avs_readdata[31:8] == 24'h00_0000
    ) else $error("upper read data nonzero");

    c_write_enable: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $rose(o_ref_enable));
    c_ready_rise: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $rose(o_ref_ready));
    c_bad_addr: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) o_avs_response == 2'b11);
    c_write_accept: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) i_avs_write && !o_avs_waitrequest);
    c_conv_x4: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) o_conv_level_sel[2]);
endmodule : fxr_ctrl_top

// ### verif/tb.sv
// Self-checking bench for the fixed reference control block
`timescale 1ns/100ps
module tb;
    import fxr_ctrl_pkg::*;
    localparam int SETTLE = 8;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [1:0] o_avs_response;
    logic o_ref_enable;
    logic o_ref_ready;
    logic lv_ready;
    logic [2:0] conv;
    logic [2:0] cmp;
    logic [2:0] lv_conv;
    logic [2:0] lv_cmp;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [1:0] rsp;

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    fxr_ctrl_top #(.HAS_LDO(1'b0), .LOW_VOLTAGE(1'b0), .SETTLE_CYCLES(SETTLE)) fxr_ctrl_top_inst (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
        .o_ref_enable(o_ref_enable), .o_ref_ready(o_ref_ready),
        .o_conv_level_sel(conv), .o_cmp_level_sel(cmp));

    // Variant with internal regulator and low supply, driven by the same bus
    fxr_ctrl_top #(.HAS_LDO(1'b1), .LOW_VOLTAGE(1'b1), .SETTLE_CYCLES(SETTLE)) fxr_ctrl_top_inst_lv (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(), .o_avs_waitrequest(),
        .o_avs_response(), .o_ref_enable(), .o_ref_ready(lv_ready),
        .o_conv_level_sel(lv_conv), .o_cmp_level_sel(lv_cmp));

    task automatic results;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        i_avs_read <= ~we;
        i_avs_write <= we;
        i_avs_address <= adr;
        i_avs_writedata <= wd;
        i_avs_byteenable <= be;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        rd = o_avs_readdata;
        rsp = o_avs_response;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (o_avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            results();
        end
        repeat (3) @(posedge i_sys_clk);
    endtask : bus

    function automatic logic [2:0] lvl(input logic en, input logic [1:0] c, input logic x4);
        if (!en || c == 2'b00 || (c == 2'b11 && !x4)) return 3'h0;
        return 3'h1 << (c - 2'b01);
    endfunction : lvl

    // Level selects of both instances and enable of the first against the enable bit and the two gain codes
    task automatic chk_out(input logic en, input logic [1:0] cc, input logic [1:0] dc);
        chk({o_ref_enable, conv, cmp}, {en, lvl(en, cc, 1'b1), lvl(en, dc, 1'b1)});
        chk({lv_conv, lv_cmp}, {lvl(en, cc, 1'b0), lvl(en, dc, 1'b1)});
    endtask : chk_out

    initial begin
        int n;
        repeat (10) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        @(posedge i_sys_clk);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(rd, 32'h0);
        chk({lv_ready, o_ref_ready, rsp}, {1'b1, 1'b0, 2'b00});
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 4'h0, 32'(8'hC0 | c * 5), 4'hF);
            chk_out(1'b1, 2'(c), 2'(c));
            bus(1'b0, 4'h0, 32'h0, 4'hF);
            chk(rd & 32'hFFFF_FFBF, 32'(8'h80 | c * 5));
        end
        bus(1'b1, 4'h0, 32'h0000_0086, 4'hF);
        chk_out(1'b1, 2'b10, 2'b01);
        $display("test gain codes done");
        bus(1'b1, 4'h3, 32'h0, 4'hF);
        chk(rsp, 2'b11);
        bus(1'b1, 4'h0, 32'h0, 4'h0);
        bus(1'b0, 4'h3, 32'h0, 4'hF);
        chk(rsp, 2'b11);
        chk(rd, 32'h0);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(rd & 32'hFFFF_FFBF, 32'h0000_0086);
        $display("test refused writes done");
        bus(1'b1, 4'h0, 32'h0000_000F, 4'hF);
        chk_out(1'b0, 2'b11, 2'b11);
        chk({lv_ready, o_ref_ready}, 2'b10);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(rd, 32'h0000_000F);
        $display("test disable done");
        bus(1'b1, 4'h0, 32'h0000_0089, 4'hF);
        chk(o_ref_ready, 1'b0);
        n = 0;
        while (o_ref_ready !== 1'b1 && n < SETTLE + 20) begin
            @(posedge i_sys_clk);
            n++;
        end
        chk(o_ref_ready, 1'b1);
        chk_out(1'b1, 2'b01, 2'b10);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(rd, 32'h0000_00C9);
        $display("test settle done");
        results();
    end
endmodule : tb
